// [pkg/ccpg_pkg.sv]
// Purpose: constants for the capture/compare pwm generator
// Assumes: axi4-lite word-aligned register map
// Notes:   offsets, fields and reset values
package ccpg_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CHANNEL_CONTROL = 8'h00;
    localparam logic [7:0] OFF_DUTY_UPPER      = 8'h04;
    localparam logic [7:0] OFF_DUTY_BUFFER     = 8'h08;
    localparam logic [7:0] OFF_PERIOD_LIMIT    = 8'h0C;
    localparam logic [7:0] OFF_TIMER_CONTROL   = 8'h10;
    localparam logic [7:0] OFF_TIMER_COUNT     = 8'h14;
    localparam logic [7:0] OFF_DEADBAND        = 8'h18;
    localparam logic [7:0] OFF_STEERING        = 8'h1C;
    localparam logic [7:0] OFF_SLEEP           = 8'h20;
    localparam logic [7:0] OFF_TIMER_SEL_LOW   = 8'h24;
    localparam logic [7:0] OFF_TIMER_SEL_HIGH  = 8'h28;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_HI = 7;
    localparam int CFG_LO = 6;
    localparam int DLOW_HI = 5;
    localparam int DLOW_LO = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 0;
    localparam int TRUN_BIT = 2;
    localparam int DB_HI = 6;
    localparam int STR_HI = 3;
    localparam int SELH_HI = 1;
    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_STEER  = 8'h01;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_HALF   = 2'h2;
    localparam logic [1:0] CFG_FWD    = 2'h1;
    localparam logic [1:0] CFG_REV    = 2'h3;
    localparam logic [1:0] PS_1       = 2'h0;
    localparam logic [1:0] PS_4       = 2'h1;
    localparam int OSC_PER_TICK = 4;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : ccpg_pkg

// [rtl/ccpg_prescaler.sv]
// Purpose: oscillator divider and timer prescaler
// Assumes: aclk is the oscillator
// Notes:   tick every 4 x prescale clocks
`timescale 1ns/1ps
module ccpg_prescaler (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [1:0] prescale,
    output logic [1:0]      low_bits,
    output logic            tick
);
    logic [1:0] osc_cnt;
    logic [3:0] pre_cnt;
    logic [3:0] pre_max;
    logic       osc_wrap;
    logic       pre_wrap;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    assign pre_max  = (prescale == ccpg_pkg::PS_1) ? 4'h0 :
                      (prescale == ccpg_pkg::PS_4) ? 4'h3 : 4'hF;
    assign osc_wrap = (osc_cnt == 2'(ccpg_pkg::OSC_PER_TICK - 1));
    assign pre_wrap = (pre_cnt >= pre_max);
    assign tick     = run && osc_wrap && pre_wrap;
    assign low_bits = (prescale == ccpg_pkg::PS_1) ? osc_cnt :
                      (prescale == ccpg_pkg::PS_4) ? pre_cnt[1:0] : pre_cnt[3:2];

    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            osc_cnt <= 2'h0;
            pre_cnt <= 4'h0;
        end else if (run) begin
            osc_cnt <= osc_cnt + 2'h1;
            if (osc_wrap) begin
                pre_cnt <= pre_wrap ? 4'h0 : pre_cnt + 4'h1;
            end
        end
    end
endmodule : ccpg_prescaler

// [rtl/ccpg_deadband.sv]
// Purpose: rising-edge delay for one output
// Assumes: delay counted in units of 4 clocks
// Notes:   output stays low if pulse shorter than delay
`timescale 1ns/1ps
module ccpg_deadband #(
    parameter int DW = 7
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          hold,
    input  wire logic          in_level,
    input  wire logic [DW-1:0] delay,
    output logic               out_level
);
    logic [DW+1:0] cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt       <= '0;
            out_level <= 1'b0;
        end else if (!hold) begin
            if (!in_level) begin
                cnt       <= '0;
                out_level <= 1'b0;
            end else if (cnt >= {delay, 2'h0}) begin
                out_level <= 1'b1;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule : ccpg_deadband

// [rtl/ccpg_top.sv]
// Purpose: 10-bit enhanced pwm with axi4-lite registers
// Assumes: aclk is the oscillator, one clock per oscillator period
// Notes:   outputs carry level and enable per pin
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - period is (limit+1) x 4 x prescale
// - period end clears timer, sets pin unless duty is zero, loads
// - postscaler never affects pwm period
// - duty is upper byte plus low bits
// - duty writes anytime, buffered at period end
// - duty buffer read-only while pwm active
// - time base low bits from osc or prescaler
// - output cleared when time base equals duty
// - pulse longer than period leaves pin set
// - resolution log2(4(limit+1)), max ten bits
// - prescale choices 1, 4 and 16
// - sleep freezes timer, outputs and state
// - reset restores registers, pins to input
// - output configuration selects bridge modes
// - mode select sets output polarity
// - zero control register releases pins
// - first enable waits for new period
// - half-bridge activation delayed by deadband
// - single mode drives steered outputs only
// - unused outputs released to other functions
// - half-bridge: a modulated, b complement
// - full-bridge forward and reverse assignments
module ccpg_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [3:0]       pwm_out,
    output logic [3:0]       pwm_oe
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  pwm_channel_control;
    logic [7:0]  duty_upper_bits;
    logic [7:0]  duty_buffer;
    logic [1:0]  duty_latch;
    logic [7:0]  period_limit;
    logic [7:0]  period_timer_control;
    logic [7:0]  period_timer_count;
    logic [6:0]  deadband_control;
    logic [3:0]  steering_control;
    logic        sleep_req;
    logic [7:0]  timer_select_low;
    logic [1:0]  timer_select_high;
    logic        started;
    logic        mod_level;
    logic [3:0]  drive_level;
    logic [3:0]  drive_en;
    // axi state
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire         do_write   = aw_held && w_held && !s_axi_bvalid;
    wire         wr_en      = do_write && w_strb[0];
    wire [7:0]   wb         = w_data[7:0];
    wire         wr_ctrl    = wr_en && aw_addr == ccpg_pkg::OFF_CHANNEL_CONTROL;
    wire         wr_dupper  = wr_en && aw_addr == ccpg_pkg::OFF_DUTY_UPPER;
    wire         wr_dbuf    = wr_en && aw_addr == ccpg_pkg::OFF_DUTY_BUFFER;
    wire         wr_period  = wr_en && aw_addr == ccpg_pkg::OFF_PERIOD_LIMIT;
    wire         wr_tctrl   = wr_en && aw_addr == ccpg_pkg::OFF_TIMER_CONTROL;
    wire         wr_tcount  = wr_en && aw_addr == ccpg_pkg::OFF_TIMER_COUNT;
    wire         wr_db      = wr_en && aw_addr == ccpg_pkg::OFF_DEADBAND;
    wire         wr_steer   = wr_en && aw_addr == ccpg_pkg::OFF_STEERING;
    wire         wr_sleep   = wr_en && aw_addr == ccpg_pkg::OFF_SLEEP;
    wire         wr_sel_lo  = wr_en && aw_addr == ccpg_pkg::OFF_TIMER_SEL_LOW;
    wire         wr_sel_hi  = wr_en && aw_addr == ccpg_pkg::OFF_TIMER_SEL_HIGH;
    wire         wr_mapped  = aw_addr <= ccpg_pkg::OFF_TIMER_SEL_HIGH && aw_addr[1:0] == 2'h0;
    wire         rd_mapped  = s_axi_araddr <= ccpg_pkg::OFF_TIMER_SEL_HIGH
                              && s_axi_araddr[1:0] == 2'h0;

    // ------------------------------------------------------------
    // mode and time base
    // ------------------------------------------------------------
    wire [3:0]   chan_mode   = pwm_channel_control[ccpg_pkg::MODE_HI:ccpg_pkg::MODE_LO];
    wire [1:0]   out_cfg     = pwm_channel_control[ccpg_pkg::CFG_HI:ccpg_pkg::CFG_LO];
    wire         pwm_active  = chan_mode[3:2] == 2'h3;
    wire         ctrl_zero   = pwm_channel_control == ccpg_pkg::RST_BYTE;
    // postscale bits 6:3 are stored but not used here
    wire         timer_run   = period_timer_control[ccpg_pkg::TRUN_BIT];
    wire [1:0]   prescale    = period_timer_control[1:0];
    wire         run         = timer_run && !sleep_req;
    wire         tick;
    wire [1:0]   low_bits;
    wire         period_end  = tick && period_timer_count == period_limit;
    wire [9:0]   duty_next   = {duty_upper_bits,
                                pwm_channel_control[ccpg_pkg::DLOW_HI:ccpg_pkg::DLOW_LO]};
    wire [9:0]   duty_cur    = {duty_buffer, duty_latch};
    wire [9:0]   time_base   = {period_timer_count, low_bits};
    // match never happens if duty beyond period
    wire         duty_match  = time_base == duty_cur;
    wire         pulse_level = mod_level && !duty_match;
    wire         pol_a_low   = chan_mode[1];
    wire         pol_b_low   = chan_mode[0];
    wire         db_a;
    wire         db_b;

    ccpg_prescaler u_prescaler (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (run),
        .restart  (period_end || wr_tcount),
        .prescale (prescale),
        .low_bits (low_bits),
        .tick     (tick)
    );

    ccpg_deadband #(.DW(7)) u_db_a (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .hold      (sleep_req),
        .in_level  (pulse_level && started),
        .delay     (deadband_control),
        .out_level (db_a)
    );

    ccpg_deadband #(.DW(7)) u_db_b (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .hold      (sleep_req),
        .in_level  (!pulse_level && started),
        .delay     (deadband_control),
        .out_level (db_b)
    );

    // ------------------------------------------------------------
    // output steering
    // ------------------------------------------------------------
    always_comb begin
        drive_level = 4'h0;
        drive_en    = 4'h0;
        if (pwm_active && started) begin
            unique case (out_cfg)
                ccpg_pkg::CFG_SINGLE: begin
                    drive_level = {4{pulse_level}};
                    drive_en    = steering_control;
                end
                ccpg_pkg::CFG_HALF: begin
                    drive_level = {2'h0, db_b, db_a};
                    drive_en    = 4'h3;
                end
                ccpg_pkg::CFG_FWD: begin
                    drive_level = {pulse_level, 2'h0, 1'b1};
                    drive_en    = 4'hF;
                end
                ccpg_pkg::CFG_REV: begin
                    drive_level = {1'b0, 1'b1, pulse_level, 1'b0};
                    drive_en    = 4'hF;
                end
            endcase
        end
    end

    // enables low after reset or zero control
    assign pwm_oe  = ctrl_zero ? 4'h0 : drive_en;
    assign pwm_out = (drive_level ^ {pol_b_low, pol_a_low, pol_b_low, pol_a_low})
                     & pwm_oe;

    // ------------------------------------------------------------
    // pwm core
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_timer_count <= ccpg_pkg::RST_BYTE;
            duty_buffer        <= ccpg_pkg::RST_BYTE;
            duty_latch         <= 2'h0;
            mod_level          <= 1'b0;
            started            <= 1'b0;
        end else begin
            if (!pwm_active) begin
                started <= 1'b0;
            end else if (period_end) begin
                started <= 1'b1;
            end
            if (wr_tcount) begin
                period_timer_count <= wb;
            end else if (period_end) begin
                period_timer_count <= 8'h00;
                duty_buffer        <= duty_next[9:2];
                duty_latch         <= duty_next[1:0];
                mod_level          <= duty_next != 10'h000;
            end else begin
                if (tick) begin
                    period_timer_count <= period_timer_count + 8'h01;
                end
                if (run && duty_match) begin
                    mod_level <= 1'b0;
                end
            end
            if (wr_dbuf && !pwm_active) begin
                duty_buffer <= wb;
            end
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_channel_control  <= ccpg_pkg::RST_BYTE;
            duty_upper_bits      <= ccpg_pkg::RST_BYTE;
            period_limit         <= ccpg_pkg::RST_PERIOD;
            period_timer_control <= ccpg_pkg::RST_BYTE;
            deadband_control     <= 7'h00;
            steering_control     <= ccpg_pkg::RST_STEER[3:0];
            sleep_req            <= 1'b0;
            timer_select_low     <= ccpg_pkg::RST_BYTE;
            timer_select_high    <= 2'h0;
        end else begin
            if (wr_ctrl)   pwm_channel_control  <= wb;
            if (wr_dupper) duty_upper_bits      <= wb;
            if (wr_period) period_limit         <= wb;
            if (wr_tctrl)  period_timer_control <= {1'b0, wb[6:0]};
            if (wr_db)     deadband_control     <= wb[ccpg_pkg::DB_HI:0];
            if (wr_steer)  steering_control     <= wb[ccpg_pkg::STR_HI:0];
            if (wr_sleep)  sleep_req            <= wb[0];
            if (wr_sel_lo) timer_select_low     <= wb;
            if (wr_sel_hi) timer_select_high    <= wb[ccpg_pkg::SELH_HI:0];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ccpg_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? ccpg_pkg::AXI_OKAY : ccpg_pkg::AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            ccpg_pkg::OFF_CHANNEL_CONTROL: rd_byte = pwm_channel_control;
            ccpg_pkg::OFF_DUTY_UPPER:      rd_byte = duty_upper_bits;
            ccpg_pkg::OFF_DUTY_BUFFER:     rd_byte = duty_buffer;
            ccpg_pkg::OFF_PERIOD_LIMIT:    rd_byte = period_limit;
            ccpg_pkg::OFF_TIMER_CONTROL:   rd_byte = period_timer_control;
            ccpg_pkg::OFF_TIMER_COUNT:     rd_byte = period_timer_count;
            ccpg_pkg::OFF_DEADBAND:        rd_byte = {1'b0, deadband_control};
            ccpg_pkg::OFF_STEERING:        rd_byte = {4'h0, steering_control};
            ccpg_pkg::OFF_SLEEP:           rd_byte = {7'h00, sleep_req};
            ccpg_pkg::OFF_TIMER_SEL_LOW:   rd_byte = timer_select_low;
            ccpg_pkg::OFF_TIMER_SEL_HIGH:  rd_byte = {6'h00, timer_select_high};
            default:                       rd_byte = 8'h00;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ccpg_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_mapped ? ccpg_pkg::AXI_OKAY : ccpg_pkg::AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : ccpg_top

// [tb/ccpg_top_sva.sv]
// Purpose: bus and pin checks on the ccpg_top ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every ccpg_top instance
`timescale 1ns/1ps
module ccpg_top_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [3:0]  pwm_out,
    input wire logic [3:0]  pwm_oe
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid not held");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_pin_released: assert property ((pwm_out & ~pwm_oe) == 4'h0)
        else $error("released pin driven high");
    a_reset_pins: assert property ($rose(aresetn) |-> pwm_oe == 4'h0)
        else $error("pins driven after reset");
    a_reset_bus: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus answer after reset");
endmodule : ccpg_top_sva
bind ccpg_top ccpg_top_sva u_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

// [tb/ccpg_load_model.sv]
// Purpose: load on one pwm pin, measures period and high time
// Assumes: pin counts only while driven
// Notes:   lengths in clocks, period rising edge to rising edge, high time rising edge to falling edge
`timescale 1ns/1ps
module ccpg_load_model (
    input  wire logic aclk,
    input  wire logic pin_level,
    input  wire logic pin_en,
    output int        period_len,
    output int        high_len
);
    logic lvl;
    logic last = 1'b0;
    int   since_rise = 0;
    int   hcnt = 0;
    assign lvl = pin_level && pin_en;
    initial period_len = 0;
    initial high_len = 0;
    always @(posedge aclk) begin
        last <= lvl;
        if (lvl && !last) begin
            period_len <= since_rise + 1;
            since_rise <= 0;
            hcnt <= 1;
        end else begin
            since_rise <= since_rise + 1;
            if (lvl) hcnt <= hcnt + 1;
        end
        if (!lvl && last) high_len <= hcnt;
    end
endmodule : ccpg_load_model

// [tb/ccpg_top_tb.sv]
// Purpose: register and waveform tests of ccpg_top
// Assumes: 250 MHz clock, limit 3 gives 16-clock periods at 1:1
// Notes:   waveform lengths measured by the load model on output a
`timescale 1ns/1ps
module ccpg_top_tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic [3:0]  pwm_out, pwm_oe, o;
    int          n_errors = 0, cmp_count = 0, per, hi;
    int          pl[3] = '{16, 64, 256};
    logic [7:0]  tc[3] = '{8'h7C, 8'h05, 8'h06};
    logic [7:0]  cf[3] = '{8'hAC, 8'h6C, 8'hEC};
    logic [3:0]  eo[3] = '{4'h3, 4'hF, 4'hF};
    logic [3:0]  mk[3] = '{4'h0, 4'h7, 4'hD};
    logic [3:0]  vl[3] = '{4'h0, 4'h1, 4'h4};
    ccpg_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
    ccpg_load_model u_load (.aclk(aclk), .pin_level(pwm_out[0]), .pin_en(pwm_oe[0]),
        .period_len(per), .high_len(hi));
    always #2 aclk = ~aclk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic tmo();
        n_errors++;
        complete_run();
    endtask : tmo
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        if (n == 100) tmo();
    endtask : wr
    task automatic rdv(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0; rd = rdata; rs = rresp;
        if (n == 100) tmo();
    endtask : rdv
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        rdv(a);
        chk(rd, exp);
        chk(32'(rs), 32'(er));
    endtask : rdc
    task automatic pin_a(input logic v);
        repeat (16) begin
            @(posedge aclk);
            chk(32'(pwm_out[0]), 32'(v));
        end
    endtask : pin_a
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(pwm_oe), 32'h0);
        rdc(ccpg_pkg::OFF_PERIOD_LIMIT, 32'hFF, ccpg_pkg::AXI_OKAY);
        rdc(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'h0, ccpg_pkg::AXI_OKAY);
        rdc(ccpg_pkg::OFF_STEERING, 32'h1, ccpg_pkg::AXI_OKAY);
        rdc(8'h40, 32'h0, ccpg_pkg::AXI_SLVERR);
        wr(8'h44, 32'h5, ccpg_pkg::AXI_SLVERR);
        wr(ccpg_pkg::OFF_PERIOD_LIMIT, 32'h3, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_DUTY_UPPER, 32'h1, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'h2C, ccpg_pkg::AXI_OKAY);
        repeat (20) @(posedge aclk);
        chk(32'(pwm_out), 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(ccpg_pkg::OFF_TIMER_CONTROL, 32'(tc[i]), ccpg_pkg::AXI_OKAY);
            repeat (3 * pl[i]) @(posedge aclk);
            chk(32'(per), 32'(pl[i]));
            chk(32'(hi), 32'(pl[i] * 6 / 16));
        end
        rdc(ccpg_pkg::OFF_DUTY_BUFFER, 32'h1, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_DUTY_BUFFER, 32'h77, ccpg_pkg::AXI_OKAY);
        rdc(ccpg_pkg::OFF_DUTY_BUFFER, 32'h1, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_DUTY_UPPER, 32'h2, ccpg_pkg::AXI_OKAY);
        repeat (3 * 256) @(posedge aclk);
        chk(32'(hi), 32'd160);
        wr(ccpg_pkg::OFF_TIMER_CONTROL, 32'h04, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_DUTY_UPPER, 32'hFF, ccpg_pkg::AXI_OKAY);
        repeat (40) @(posedge aclk);
        pin_a(1'b1);
        wr(ccpg_pkg::OFF_DUTY_UPPER, 32'h0, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'h0C, ccpg_pkg::AXI_OKAY);
        repeat (40) @(posedge aclk);
        pin_a(1'b0);
        wr(ccpg_pkg::OFF_DUTY_UPPER, 32'h1, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'h2F, ccpg_pkg::AXI_OKAY);
        repeat (50) @(posedge aclk);
        chk(32'(hi), 32'd10);
        wr(ccpg_pkg::OFF_SLEEP, 32'h1, ccpg_pkg::AXI_OKAY);
        rdv(ccpg_pkg::OFF_TIMER_COUNT);
        o = pwm_out;
        repeat (30) @(posedge aclk);
        chk(32'(pwm_out), 32'(o));
        rdc(ccpg_pkg::OFF_TIMER_COUNT, rd, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_SLEEP, 32'h0, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'h2C, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_STEERING, 32'h5, ccpg_pkg::AXI_OKAY);
        @(posedge aclk);
        chk(32'(pwm_oe), 32'h5);
        wr(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'hAC, ccpg_pkg::AXI_OKAY);
        wr(ccpg_pkg::OFF_DEADBAND, 32'h1, ccpg_pkg::AXI_OKAY);
        repeat (50) @(posedge aclk);
        chk(32'(hi), 32'd2);
        wr(ccpg_pkg::OFF_DEADBAND, 32'h0, ccpg_pkg::AXI_OKAY);
        for (int i = 0; i < 3; i++) begin
            wr(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'(cf[i]), ccpg_pkg::AXI_OKAY);
            repeat (40) @(posedge aclk);
            chk(32'(pwm_oe), 32'(eo[i]));
            chk(32'(pwm_out & mk[i]), 32'(vl[i]));
            repeat (8) begin
                @(posedge aclk);
                if (i == 0) chk(32'(pwm_out[1]), 32'(!pwm_out[0]));
            end
        end
        wr(ccpg_pkg::OFF_CHANNEL_CONTROL, 32'h0, ccpg_pkg::AXI_OKAY);
        @(posedge aclk);
        chk(32'(pwm_oe), 32'h0);
        complete_run();
    end
endmodule : ccpg_top_tb
